// [hw/asm_ctrl.v]
// Async SRAM/EPROM access sequencer with AHB-Lite register slave
//
// Chosen here: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "asm_defs.vh"
module asm_ctrl #(
	parameter PORT_WIDE = 1
) (
	input wire sys_clk,
	input wire nrst,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire hready,
	input wire [31:0] hwdata,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	input wire async_ready_in,
	input wire [(PORT_WIDE ? 64 : 16)-1:0] mem_data_bus_in,
	output reg [(PORT_WIDE ? 64 : 16)-1:0] mem_data_bus_out,
	output reg mem_data_bus_oe,
	output reg [19:0] mem_address_bus,
	output reg [`ASM_NSPACE-1:0] space_select_n,
	output reg [(PORT_WIDE ? 8 : 2)-1:0] byte_lane_select_n,
	output reg output_enable_strobe_n,
	output reg read_strobe_n,
	output reg write_strobe_pulse_n
);

	localparam DW = PORT_WIDE ? 64 : 16;
	localparam BW = PORT_WIDE ? 8 : 2;

	localparam ST_IDLE = 2'b00;
	localparam ST_SETUP = 2'b01;
	localparam ST_STRB = 2'b10;
	localparam ST_HOLD = 2'b11;

	// ************************************************************
	// AHB-Lite register slave
	// ************************************************************
	wire [31:0] ctl_w [0:`ASM_NSPACE-1];
	reg [19:0] addr_q;
	reg [31:0] wdlo_q;
	reg [31:0] wdhi_q;
	reg [63:0] rdat_q;
	reg done_q;
	reg wr_pend_q;
	reg rd_pend_q;
	reg [7:0] ofs_q;
	reg [1:0] st_q;
	reg [5:0] cnt_q;
	reg ext_q;
	reg is_wr_q;
	reg [1:0] sp_q;
	reg rdy_m_q;
	reg rdy_s_q;

	wire busy = (st_q != ST_IDLE);
	wire acc = hsel && htrans[1] && hready && hreadyout;
	wire wr_cmd = wr_pend_q && (ofs_q == `ASM_OFS_CMD);
	wire go = wr_cmd && hwdata[`ASM_CMD_GO] && !busy;
	wire clr_done = wr_pend_q && (ofs_q == `ASM_OFS_STAT) &&
		hwdata[`ASM_ST_DONE];
	wire fin = (st_q == ST_HOLD) && (cnt_q == 6'h00);

	reg [31:0] rd_mux;
	always @* begin
		rd_mux = 32'h00000000;
		if (ofs_q[7:4] == 4'h0 && ofs_q[1:0] == 2'b00)
			rd_mux = ctl_w[ofs_q[3:2]];
		else begin
			case (ofs_q)
			`ASM_OFS_ADDR: rd_mux = {12'h000, addr_q};
			`ASM_OFS_WDLO: rd_mux = wdlo_q;
			`ASM_OFS_WDHI: rd_mux = wdhi_q;
			`ASM_OFS_STAT: rd_mux = {30'h00000000, done_q, busy};
			`ASM_OFS_RDLO: rd_mux = rdat_q[31:0];
			`ASM_OFS_RDHI: rd_mux = rdat_q[63:32];
			default: rd_mux = 32'h00000000;
			endcase
		end
	end

	// Reads take one wait state so hrdata comes from a flop
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			ofs_q <= 8'h00;
		end else begin
			hresp <= 1'b0;
			wr_pend_q <= acc && hwrite;
			rd_pend_q <= acc && !hwrite;
			if (acc)
				ofs_q <= haddr[7:0];
			if (acc && !hwrite) begin
				hreadyout <= 1'b0;
			end else if (rd_pend_q) begin
				hreadyout <= 1'b1;
				hrdata <= rd_mux;
			end
		end
	end

	// ************************************************************
	// Per-space timing registers
	// ************************************************************
	// One register per space; reserved bits never stored
	genvar g;
	generate
		for (g = 0; g < `ASM_NSPACE; g = g + 1) begin : g_space
			reg [31:0] space_ctl_q;
			wire hit = wr_pend_q && ({24'h000000, ofs_q} == g * 4);
			always @(posedge sys_clk or negedge nrst) begin
				if (!nrst)
					space_ctl_q <= `ASM_CTL_RST;
				else if (hit)
					space_ctl_q <= hwdata & `ASM_CTL_MASK;
			end
			assign ctl_w[g] = space_ctl_q;
		end
	endgenerate

	// ************************************************************
	// Address and write data registers
	// ************************************************************
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			addr_q <= 20'h00000;
			wdlo_q <= 32'h00000000;
			wdhi_q <= 32'h00000000;
		end else if (wr_pend_q) begin
			case (ofs_q)
			`ASM_OFS_ADDR: addr_q <= hwdata[19:0];
			`ASM_OFS_WDLO: wdlo_q <= hwdata;
			`ASM_OFS_WDHI: wdhi_q <= hwdata;
			default: ;
			endcase
		end
	end

	// Set wins over a clear in the same cycle
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			done_q <= 1'b0;
		else if (fin)
			done_q <= 1'b1;
		else if (clr_done)
			done_q <= 1'b0;
	end

	// ************************************************************
	// Ready synchroniser
	// ************************************************************
	// Memory drives ready with no fixed phase to our clock
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rdy_m_q <= 1'b1;
			rdy_s_q <= 1'b1;
		end else begin
			rdy_m_q <= async_ready_in;
			rdy_s_q <= rdy_m_q;
		end
	end

	// ************************************************************
	// Access sequencer
	// ************************************************************
	wire [31:0] cs = ctl_w[sp_q];
	wire [31:0] cn = ctl_w[hwdata[`ASM_F_SPACE]];
	// A zero count still gives one cycle so phases never vanish
	wire [5:0] su_n = hwdata[`ASM_CMD_WR] ? {2'b00, cn[`ASM_F_WS]} :
		{2'b00, cn[`ASM_F_RS]};
	wire [5:0] sb_n = is_wr_q ? cs[`ASM_F_WST] : cs[`ASM_F_RST];
	wire [5:0] hd_n = is_wr_q ? {3'b000, cs[`ASM_F_WH]} :
		{3'b000, cs[`ASM_F_RH]};
	wire in_win = (cnt_q < `ASM_RDY_WIN);
	wire [63:0] wfull = {wdhi_q, wdlo_q};

	// ************************************************************
	// Read data widening
	// ************************************************************
	// A zero-width fill is illegal, so the wide port skips it
	wire [63:0] rd_pins;
	generate
		if (DW == 64) begin : g_rd_wide
			assign rd_pins = mem_data_bus_in;
		end else begin : g_rd_narrow
			assign rd_pins = {{(64-DW){1'b0}}, mem_data_bus_in};
		end
	endgenerate

	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			st_q <= ST_IDLE;
			cnt_q <= 6'h00;
			ext_q <= 1'b0;
			is_wr_q <= 1'b0;
			sp_q <= 2'b00;
			rdat_q <= 64'h0000000000000000;
			mem_data_bus_out <= {DW{1'b0}};
			mem_data_bus_oe <= 1'b0;
			mem_address_bus <= 20'h00000;
			space_select_n <= {`ASM_NSPACE{1'b1}};
			byte_lane_select_n <= {BW{1'b1}};
			output_enable_strobe_n <= 1'b1;
			read_strobe_n <= 1'b1;
			write_strobe_pulse_n <= 1'b1;
		end else begin
			case (st_q)
			ST_IDLE: begin
				if (go) begin
					// selects become valid for the setup phase
					st_q <= ST_SETUP;
					is_wr_q <= hwdata[`ASM_CMD_WR];
					sp_q <= hwdata[`ASM_F_SPACE];
					cnt_q <= (su_n == 6'h00) ? 6'h00 : su_n - 6'h01;
					mem_address_bus <= addr_q;
					space_select_n <= ~(4'h1 << hwdata[`ASM_F_SPACE]);
					byte_lane_select_n <= ~hwdata[8 +: BW];
					// enable used only as read output enable
					output_enable_strobe_n <= hwdata[`ASM_CMD_WR];
					mem_data_bus_out <= wfull[DW-1:0];
					mem_data_bus_oe <= hwdata[`ASM_CMD_WR];
				end
			end
			ST_SETUP: begin
				if (cnt_q == 6'h00) begin
					st_q <= ST_STRB;
					ext_q <= 1'b0;
					cnt_q <= (sb_n == 6'h00) ? 6'h00 : sb_n - 6'h01;
					read_strobe_n <= is_wr_q;
					write_strobe_pulse_n <= !is_wr_q;
				end else
					cnt_q <= cnt_q - 6'h01;
			end
			ST_STRB: begin
				if (in_win && !rdy_s_q) begin
					ext_q <= 1'b1;
				end else if (ext_q) begin
					// two more cycles after ready seen high
					ext_q <= 1'b0;
					cnt_q <= 6'h01;
				end else if (cnt_q == 6'h00) begin
					// strobe rises; read data taken on this edge
					st_q <= ST_HOLD;
					cnt_q <= (hd_n == 6'h00) ? 6'h00 : hd_n - 6'h01;
					read_strobe_n <= 1'b1;
					write_strobe_pulse_n <= 1'b1;
					if (!is_wr_q)
						rdat_q <= rd_pins;
				end else
					cnt_q <= cnt_q - 6'h01;
			end
			ST_HOLD: begin
				if (cnt_q == 6'h00) begin
					st_q <= ST_IDLE;
					space_select_n <= {`ASM_NSPACE{1'b1}};
					byte_lane_select_n <= {BW{1'b1}};
					output_enable_strobe_n <= 1'b1;
					mem_data_bus_oe <= 1'b0;
				end else
					cnt_q <= cnt_q - 6'h01;
			end
			default: st_q <= ST_IDLE;
			endcase
		end
	end

endmodule
`default_nettype wire

// [pkg/asm_defs.vh]
// Register map, field layout and constants of the async memory sequencer
`ifndef ASM_DEFS_VH
`define ASM_DEFS_VH

// ************************************************************
// Register byte offsets (haddr[7:0])
// ************************************************************
`define ASM_OFS_CTL0 8'h00
`define ASM_OFS_CTL3 8'h0C
`define ASM_OFS_ADDR 8'h10
`define ASM_OFS_WDLO 8'h14
`define ASM_OFS_WDHI 8'h18
`define ASM_OFS_CMD 8'h1C
`define ASM_OFS_STAT 8'h20
`define ASM_OFS_RDLO 8'h24
`define ASM_OFS_RDHI 8'h28

// ************************************************************
// Space control register fields
// ************************************************************
`define ASM_F_WS 31:28
`define ASM_F_WST 27:22
`define ASM_F_WH 21:19
`define ASM_F_RS 17:14
`define ASM_F_RST 13:8
`define ASM_F_RH 2:0
`define ASM_CTL_MASK 32'hFFFBFF07
`define ASM_CTL_RST 32'hFFFBFF07

// ************************************************************
// Command and status fields
// ************************************************************
`define ASM_CMD_GO 0
`define ASM_CMD_WR 1
`define ASM_F_SPACE 3:2
`define ASM_F_LANES 15:8
`define ASM_ST_BUSY 0
`define ASM_ST_DONE 1

// ************************************************************
// Timing and space count
// ************************************************************
`define ASM_RDY_WIN 6'h02
`define ASM_NSPACE 4

`endif

// [tb/asm_ctrl_assertions.sv]
// Port checks for the async access sequencer
`timescale 1ns/100ps
`default_nettype none
module asm_ctrl_assertions #(
	parameter PORT_WIDE = 1
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic async_ready_in,
	input wire logic [(PORT_WIDE ? 64 : 16)-1:0] mem_data_bus_out,
	input wire logic mem_data_bus_oe,
	input wire logic [19:0] mem_address_bus,
	input wire logic [3:0] space_select_n,
	input wire logic output_enable_strobe_n,
	input wire logic read_strobe_n,
	input wire logic write_strobe_pulse_n
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	sequence s_rd_req;
		hsel && htrans[1] && hready && hreadyout && !hwrite;
	endsequence
	sequence s_rdy_back;
		!read_strobe_n && $rose(async_ready_in);
	endsequence
	a_resp_okay: assert property (!hresp) else $error("bad resp");
	a_read_wait: assert property (s_rd_req |=> !hreadyout ##1 hreadyout)
		else $error("read wait");
	a_setup_read: assert property ($fell(read_strobe_n) |->
		!output_enable_strobe_n && !$past(output_enable_strobe_n))
		else $error("read setup");
	a_hold_read: assert property ($rose(read_strobe_n) |->
		space_select_n != 4'hF && $stable(mem_address_bus))
		else $error("read hold");
	a_setup_write: assert property ($fell(write_strobe_pulse_n) |->
		mem_data_bus_oe && $stable(mem_data_bus_out))
		else $error("write setup");
	a_hold_write: assert property ($rose(write_strobe_pulse_n) |->
		mem_data_bus_oe && space_select_n != 4'hF)
		else $error("write hold");
	a_strobe_excl: assert property (read_strobe_n || write_strobe_pulse_n)
		else $error("both strobes");
	a_ready_stretch: assert property (
		(!read_strobe_n && !async_ready_in)[*4] |=> !read_strobe_n)
		else $error("no stretch");
	a_ready_end: assert property (
		s_rdy_back |-> ##1 !read_strobe_n ##[1:5] read_strobe_n)
		else $error("stretch end");
endmodule
bind asm_ctrl asm_ctrl_assertions #(.PORT_WIDE(PORT_WIDE)) asm_chk_i (
	.sys_clk(sys_clk), .nrst(nrst), .hsel(hsel), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.async_ready_in(async_ready_in), .mem_data_bus_out(mem_data_bus_out),
	.mem_data_bus_oe(mem_data_bus_oe), .mem_address_bus(mem_address_bus),
	.space_select_n(space_select_n),
	.output_enable_strobe_n(output_enable_strobe_n),
	.read_strobe_n(read_strobe_n), .write_strobe_pulse_n(write_strobe_pulse_n));
`default_nettype wire

// [tb/asm_ctrl_tb.sv]
// Register-level bench of the async access sequencer
`timescale 1ns/100ps
`default_nettype none
`include "asm_defs.vh"
module asm_ctrl_tb;
	logic sys_clk = 0, nrst = 0, hsel = 0, hwrite = 0, rdy, hreadyout;
	logic hresp, oe, oe_n, re_n, we_n;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [63:0] din, dout, dat;
	logic [19:0] addr, ma;
	logic [3:0] cs_n, wt = 4'h0;
	logic [7:0] be_n;
	int n_errors = 0, comparisons = 0, su, st, ho;
	asm_ctrl #(.PORT_WIDE(1)) asm_ctrl_i (.sys_clk(sys_clk), .nrst(nrst),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .async_ready_in(rdy),
		.mem_data_bus_in(dout), .mem_data_bus_out(din), .mem_data_bus_oe(oe),
		.mem_address_bus(addr), .space_select_n(cs_n),
		.byte_lane_select_n(be_n), .output_enable_strobe_n(oe_n),
		.read_strobe_n(re_n), .write_strobe_pulse_n(we_n));
	asm_mem_model asm_mem_model_i (.sys_clk(sys_clk), .addr(addr),
		.cs_n(cs_n), .oe_n(oe_n), .re_n(re_n), .we_n(we_n), .be_n(be_n),
		.din(din), .wt(wt), .dout(dout), .rdy(rdy));
	initial begin
		forever #25 sys_clk = ~sys_clk;
	end
	// Phase lengths seen on the pins, in clock periods
	always @(posedge sys_clk) begin
		if (cs_n != 4'hF) begin
			if (!re_n || !we_n) begin
				st++;
				ma = addr;
			end
			else if (st == 0) su++;
			else ho++;
		end
	end
	task chk(input logic [63:0] got, input logic [63:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		hsel <= 1'b1;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task run(input logic [31:0] cmd, input int s, input int h);
		su = 0;
		st = 0;
		ho = 0;
		xfer(1'b1, `ASM_OFS_CMD, cmd);
		do xfer(1'b0, `ASM_OFS_STAT, 0); while (rd[`ASM_ST_DONE] !== 1'b1);
		xfer(1'b1, `ASM_OFS_STAT, 32'h2);
		xfer(1'b0, `ASM_OFS_RDLO, 0);
		dat[31:0] = rd;
		xfer(1'b0, `ASM_OFS_RDHI, 0);
		dat[63:32] = rd;
		chk(su, s);
		chk(ho, h);
		chk(ma, 20'h5);
	endtask
	task print_verdict;
		$display("comparisons %0d n_errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		#200000;
		n_errors++;
		print_verdict;
	end
	initial begin
		repeat (4) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		xfer(1'b0, `ASM_OFS_CTL0, 0);
		chk(rd, `ASM_CTL_RST);
		xfer(1'b0, 8'h30, 0);
		chk(rd, 0);
		// Strobe kept wide so read data never leans on ready
		xfer(1'b1, `ASM_OFS_CTL0, 32'h20D0C401);
		xfer(1'b1, `ASM_OFS_CTL3, 32'h10484203);
		xfer(1'b0, `ASM_OFS_CTL0, 0);
		chk(rd, 32'h20D0C401);
		xfer(1'b1, `ASM_OFS_ADDR, 32'h5);
		xfer(1'b1, `ASM_OFS_WDLO, 32'h12345678);
		xfer(1'b1, `ASM_OFS_WDHI, 32'hCAFEF00D);
		run(32'h0F03, 2, 2);
		chk(st, 3);
		run(32'hFF0D, 1, 3);
		chk(st, 2);
		chk(dat, 64'h12345678);
		// Ready back high before the window opens: no stretch
		wt <= 4'h2;
		run(32'hFF01, 3, 1);
		chk(st, 4);
		wt <= 4'h6;
		run(32'hFF01, 3, 1);
		chk(st > 4, 1);
		chk(st, 9);
		chk(dat, 64'h12345678);
		print_verdict;
	end
endmodule
`default_nettype wire

// [tb/asm_mem_model.sv]
// Async SRAM model with a ready line held low after select
`timescale 1ns/100ps
`default_nettype none
module asm_mem_model (
	input wire logic sys_clk,
	input wire logic [19:0] addr,
	input wire logic [3:0] cs_n,
	input wire logic oe_n,
	input wire logic re_n,
	input wire logic we_n,
	input wire logic [7:0] be_n,
	input wire logic [63:0] din,
	input wire logic [3:0] wt,
	output logic [63:0] dout,
	output logic rdy
);
	logic [63:0] mem [16];
	logic [63:0] last = 64'h0;
	int n = 0;
	initial begin
		rdy = 1'b1;
		foreach (mem[i]) mem[i] = 64'h0;
	end
	// Released bus shows the inverse so stale data cannot pass
	assign dout = (!oe_n && !re_n) ? mem[addr[3:0]] : ~last;
	always @(posedge sys_clk) begin
		n <= (cs_n == 4'hF) ? 0 : n + 1;
		rdy <= #13 (n >= wt);
		if (!re_n)
			last <= mem[addr[3:0]];
	end
	always @(posedge we_n) begin
		for (int b = 0; b < 8; b++)
			if (cs_n != 4'hF && !be_n[b])
				mem[addr[3:0]][8*b+:8] <= din[8*b+:8];
	end
endmodule
`default_nettype wire
